// ### common/lduc_pkg.sv
package lduc_pkg;
    // instruction field positions
    localparam int OPC_HI = 31;
    localparam int OPC_LO = 26;
    localparam int BASE_HI = 25;
    localparam int BASE_LO = 21;
    localparam int DEST_HI = 20;
    localparam int DEST_LO = 16;
    localparam int IMM_HI = 15;
    localparam int IMM_LO = 0;
    // primary opcodes handled here
    localparam logic [5:0] OP_LOAD_DOUBLEWORD = 6'h37;
    localparam logic [5:0] OP_LEFT_MERGE = 6'h1a;
    localparam logic [5:0] OP_RIGHT_MERGE = 6'h1b;
    localparam logic [5:0] OP_SIGNED_HALF = 6'h21;
    localparam logic [5:0] OP_UNSIGNED_HALF = 6'h25;
    localparam logic [5:0] OP_UPPER_IMM = 6'h0f;
    localparam logic [5:0] OP_WORD_LOAD = 6'h23;
    // register byte offsets on the control bus
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_INFO = 8'h0c;
    // control register bit positions
    localparam int CTL_MODE64 = 0;
    localparam int CTL_KERNEL = 1;
    localparam int CTL_MEM_ORDER = 2;
    localparam int CTL_ORDER_FLIP = 3;
    localparam int CTL_CPU_ORDER = 4;
    localparam int CTL_W = 5;
    localparam logic [4:0] CTRL_RST = 5'h00;
    // status and mask: one bit per exception kind, bit = code - 1
    localparam int NEV = 5;
    localparam logic [4:0] MASK_RST = 5'h00;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // exception kinds reported with each write-back
    typedef enum logic [2:0] {
        EXC_NONE = 3'b000,
        EXC_ADDR = 3'b001,
        EXC_RSV = 3'b010,
        EXC_REFILL = 3'b011,
        EXC_INVALID = 3'b100,
        EXC_BUS = 3'b101
    } lduc_exc_t;

    // control sequence
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ = 2'b01,
        ST_RESP = 2'b10,
        ST_DONE = 2'b11
    } lduc_state_t;

    // instruction issued by the pipeline with its operands
    typedef struct packed {
        logic [31:0] instr;
        logic [63:0] base;
        logic [63:0] dest_val;
    } lduc_iss_t;

    // load request to translation and memory
    typedef struct packed {
        logic [63:0] virtual_address;
        logic [2:0] poff;
        logic [5:0] op;
    } lduc_mreq_t;

    // load answer from memory
    typedef struct packed {
        logic [63:0] data;
        logic refill;
        logic invalid;
        logic bus_err;
    } lduc_mrsp_t;

    // general register write-back
    typedef struct packed {
        logic [4:0] dest;
        logic [63:0] data;
        lduc_exc_t exc;
    } lduc_wb_t;
endpackage

// ### src/lduc_merge.sv
module lduc_merge (
    // merge selection
    input wire logic left_i,
    input wire logic [2:0] byte_i,
    // data in
    input wire logic [63:0] mem_i,
    input wire logic [63:0] old_i,
    // merged result
    output logic [63:0] res_o
);
    ////////////////////////////////////////////////////////////////
    // one lane per register byte; s is lane plus byte index
    for (genvar k = 0; k < 8; k++) begin : g_lane
        localparam logic [3:0] K = 4'(k);
        logic [3:0] s;
        logic take;
        logic [2:0] src;
        assign s = K + {1'b0, byte_i};
        // left fills from the top, right from the bottom
        assign take = left_i ? (s >= 4'h7) : (s <= 4'h7);
        // left source byte is s - 7, right source is s itself
        assign src = left_i ? 3'(s - 4'h7) : s[2:0];
        // untouched lanes keep the old register byte
        assign res_o[8*k +: 8] = take ? mem_i[{src, 3'h0} +: 8] : old_i[8*k +: 8];
    end
endmodule

// ### src/lduc_core.sv
// Function
// - opcode 110111 loads full doubleword
// - address is base plus sign-extended offset
// - doubleword load faults on low three bits
// - doubleword loads need 64-bit or kernel
// - opcode 011010 left merge into top bytes
// - little-endian left merge sends offset zero
// - merges read one doubleword, never misaligned
// - forward previous result into following merge
// - opcode 011011 right merge into low bytes
// - little-endian right merge keeps address offset
// - left: flip offset, clear if little-endian
// - right: flip offset, clear if big-endian
// - opcode 100001 signed halfword, odd faults
// - opcode 100101 unsigned halfword, odd faults
// - opcode 001111 immediate into upper half
// - opcode 100011 word load, bits 1..0 checked
// - doubleword loads report five faults, other memory loads four, immediate none
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
module lduc_core (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // pipeline issue
    input wire logic iss_valid_i,
    input wire lduc_pkg::lduc_iss_t iss_i,
    output logic iss_ready_o,
    // general register write-back
    output logic wb_valid_o,
    output lduc_pkg::lduc_wb_t wb_o,
    // translation and memory load path
    output logic mreq_valid_o,
    output lduc_pkg::lduc_mreq_t mreq_o,
    input wire logic mreq_ready_i,
    input wire logic mrsp_valid_i,
    input wire lduc_pkg::lduc_mrsp_t mrsp_i,
    // axi4-lite write address and data
    input wire logic [7:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    // axi4-lite write response
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    // axi4-lite read
    input wire logic [7:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    // interrupt
    output logic irq_o
);
    ////////////////////////////////////////////////////////////////
    // state and registers
    lduc_pkg::lduc_state_t state; // control sequence
    logic [4:0] ctrl; // mode and byte order settings
    logic [4:0] stat; // sticky exception events
    logic [4:0] mask; // interrupt enables
    logic [5:0] op; // latched opcode
    logic [4:0] dest; // latched destination register
    logic [63:0] ea; // latched effective address
    logic [63:0] old; // destination value before the load
    logic [2:0] poff; // physical low offset to memory
    lduc_pkg::lduc_exc_t exc; // outcome of current instruction
    logic [63:0] wbd; // result to write back
    logic fwd_v; // previous result still forwardable
    logic [4:0] fwd_reg; // register it went to
    logic [63:0] fwd_data; // value it got

    // configuration views
    logic mode64;
    logic kernel;
    logic mem_byte_order;
    logic user_order_flip;
    logic processor_byte_order;
    assign mode64 = ctrl[lduc_pkg::CTL_MODE64];
    assign kernel = ctrl[lduc_pkg::CTL_KERNEL];
    assign mem_byte_order = ctrl[lduc_pkg::CTL_MEM_ORDER];
    assign user_order_flip = ctrl[lduc_pkg::CTL_ORDER_FLIP];
    assign processor_byte_order = ctrl[lduc_pkg::CTL_CPU_ORDER];

    ////////////////////////////////////////////////////////////////
    // decode of the issued word
    logic [5:0] d_op;
    logic [4:0] d_dest;
    logic [15:0] d_off;
    logic [63:0] d_ea;
    logic d_dw;
    logic d_mem;
    logic d_rsv;
    logic d_aln;
    logic [63:0] d_old;
    logic [2:0] d_poff;
    logic acc;

    // fixed field slicing
    assign d_op = iss_i.instr[lduc_pkg::OPC_HI:lduc_pkg::OPC_LO];
    assign d_dest = iss_i.instr[lduc_pkg::DEST_HI:lduc_pkg::DEST_LO];
    assign d_off = iss_i.instr[lduc_pkg::IMM_HI:lduc_pkg::IMM_LO];
    // effective address, same adder for every load
    assign d_ea = iss_i.base + {{48{d_off[15]}}, d_off};
    // doubleword family
    assign d_dw = (d_op == lduc_pkg::OP_LOAD_DOUBLEWORD)
        || (d_op == lduc_pkg::OP_LEFT_MERGE)
        || (d_op == lduc_pkg::OP_RIGHT_MERGE);
    // all memory loads
    assign d_mem = d_dw || (d_op == lduc_pkg::OP_SIGNED_HALF)
        || (d_op == lduc_pkg::OP_UNSIGNED_HALF)
        || (d_op == lduc_pkg::OP_WORD_LOAD);
    // 32-bit user or supervisor may not run doubleword loads
    assign d_rsv = d_dw && !mode64 && !kernel;
    // an accepted instruction of any opcode; unknown opcodes are dropped by the control sequence
    assign acc = iss_valid_i && iss_ready_o;

    // alignment check per access size; merges never fault on alignment
    always_comb begin
        case (d_op)
            lduc_pkg::OP_LOAD_DOUBLEWORD: d_aln = |d_ea[2:0];
            lduc_pkg::OP_SIGNED_HALF: d_aln = d_ea[0];
            lduc_pkg::OP_UNSIGNED_HALF: d_aln = d_ea[0];
            lduc_pkg::OP_WORD_LOAD: d_aln = |d_ea[1:0];
            default: d_aln = 1'b0;
        endcase
    end

    // physical offset: merges xor with flip, then clear per side
    always_comb begin
        d_poff = d_ea[2:0];
        if (d_op == lduc_pkg::OP_LEFT_MERGE) begin
            d_poff = d_ea[2:0] ^ {3{user_order_flip}};
            if (!mem_byte_order) begin
                d_poff = 3'h0;
            end
        end else if (d_op == lduc_pkg::OP_RIGHT_MERGE) begin
            d_poff = d_ea[2:0] ^ {3{user_order_flip}};
            if (mem_byte_order) begin
                d_poff = 3'h0;
            end
        end
    end

    // bypass: the register file may not yet hold the last result
    assign d_old = (fwd_v && fwd_reg == d_dest) ? fwd_data : iss_i.dest_val;

    ////////////////////////////////////////////////////////////////
    // control sequence: accept, request, wait answer, write back
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state <= lduc_pkg::ST_IDLE;
        end else begin
            case (state)
                lduc_pkg::ST_IDLE: begin
                    // immediate loads and early faults skip memory
                    if (acc && d_op == lduc_pkg::OP_UPPER_IMM) begin
                        state <= lduc_pkg::ST_DONE;
                    end else if (acc && d_mem && (d_rsv || d_aln)) begin
                        state <= lduc_pkg::ST_DONE;
                    end else if (acc && d_mem) begin
                        state <= lduc_pkg::ST_REQ;
                    end
                end
                lduc_pkg::ST_REQ: begin
                    // hold request until taken
                    if (mreq_ready_i) begin
                        state <= lduc_pkg::ST_RESP;
                    end
                end
                lduc_pkg::ST_RESP: begin
                    if (mrsp_valid_i) begin
                        state <= lduc_pkg::ST_DONE;
                    end
                end
                lduc_pkg::ST_DONE: state <= lduc_pkg::ST_IDLE;
                default: state <= lduc_pkg::ST_IDLE;
            endcase
        end
    end

    // operand capture at acceptance
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            op <= 6'h00;
            dest <= 5'h00;
            ea <= 64'h0;
            old <= 64'h0;
            poff <= 3'h0;
        end else if (acc) begin
            op <= d_op;
            dest <= d_dest;
            ea <= d_ea;
            old <= d_old;
            poff <= d_poff;
        end
    end

    ////////////////////////////////////////////////////////////////
    // result formation
    logic [2:0] byte_idx; // byte index within the doubleword
    logic [1:0] hsel; // halfword lane
    logic wsel; // word lane
    logic [15:0] half;
    logic [31:0] word;
    logic [63:0] merged;
    logic [63:0] next_wbd;
    logic [63:0] lui_val;

    assign byte_idx = ea[2:0] ^ {3{processor_byte_order}};
    assign hsel = ea[2:1] ^ {2{processor_byte_order}};
    assign wsel = ea[2] ^ processor_byte_order;
    assign half = mrsp_i.data[{hsel, 4'h0} +: 16];
    assign word = mrsp_i.data[{wsel, 5'h00} +: 32];

    // byte lane merge for both unaligned forms
    lduc_merge u_lduc_merge (
        .left_i(op == lduc_pkg::OP_LEFT_MERGE),
        .byte_i(byte_idx),
        .mem_i(mrsp_i.data),
        .old_i(old),
        .res_o(merged)
    );

    // immediate above sixteen zeros, widened per mode
    assign lui_val = mode64 ? {{32{d_off[15]}}, d_off, 16'h0000}
        : {32'h0, d_off, 16'h0000};

    // loaded value by opcode
    always_comb begin
        case (op)
            lduc_pkg::OP_LOAD_DOUBLEWORD: next_wbd = mrsp_i.data;
            lduc_pkg::OP_LEFT_MERGE: next_wbd = merged;
            lduc_pkg::OP_RIGHT_MERGE: next_wbd = merged;
            lduc_pkg::OP_SIGNED_HALF: next_wbd = {{48{half[15]}}, half};
            lduc_pkg::OP_UNSIGNED_HALF: next_wbd = {48'h0, half};
            lduc_pkg::OP_WORD_LOAD: begin
                // upper half is only meaningful in 64-bit mode
                next_wbd = mode64 ? {{32{word[31]}}, word} : {32'h0, word};
            end
            default: next_wbd = old;
        endcase
    end

    // result and outcome registers
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wbd <= 64'h0;
            exc <= lduc_pkg::EXC_NONE;
        end else if (acc) begin
            wbd <= lui_val;
            if (d_rsv) begin
                exc <= lduc_pkg::EXC_RSV;
            end else if (d_aln) begin
                exc <= lduc_pkg::EXC_ADDR;
            end else begin
                exc <= lduc_pkg::EXC_NONE;
            end
        end else if (state == lduc_pkg::ST_RESP && mrsp_valid_i) begin
            wbd <= next_wbd;
            // translation faults take precedence over bus error
            if (mrsp_i.refill) begin
                exc <= lduc_pkg::EXC_REFILL;
            end else if (mrsp_i.invalid) begin
                exc <= lduc_pkg::EXC_INVALID;
            end else if (mrsp_i.bus_err) begin
                exc <= lduc_pkg::EXC_BUS;
            end
        end
    end

    // forward window: only the very next accepted instruction
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            fwd_v <= 1'b0;
            fwd_reg <= 5'h00;
            fwd_data <= 64'h0;
        end else if (state == lduc_pkg::ST_DONE) begin
            fwd_v <= (exc == lduc_pkg::EXC_NONE);
            fwd_reg <= dest;
            fwd_data <= wbd;
        end else if (acc) begin
            fwd_v <= 1'b0;
        end
    end

    // pipeline and memory facing outputs
    assign iss_ready_o = (state == lduc_pkg::ST_IDLE);
    assign wb_valid_o = (state == lduc_pkg::ST_DONE);
    assign wb_o = '{dest: dest, data: wbd, exc: exc};
    assign mreq_valid_o = (state == lduc_pkg::ST_REQ);
    assign mreq_o = '{virtual_address: ea, poff: poff, op: op};

    ////////////////////////////////////////////////////////////////
    // axi4-lite slave; write and read each one at a time
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_wr;
    logic rd_stat;
    logic [4:0] ev;

    assign awready_o = !aw_hold;
    assign wready_o = !w_hold;
    assign arready_o = !rvalid_o;
    // write fires once both halves are held and the answer slot is free
    assign do_wr = aw_hold && w_hold && !bvalid_o;
    assign rd_stat = arvalid_i && arready_o && araddr_i == lduc_pkg::REG_STATUS;

    // address and data may arrive in either order
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            aw_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_hold <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else begin
            if (awvalid_i && awready_o) begin
                aw_hold <= 1'b1;
                aw_addr <= awaddr_i;
            end else if (do_wr) begin
                aw_hold <= 1'b0;
            end
            if (wvalid_i && wready_o) begin
                w_hold <= 1'b1;
                w_data <= wdata_i;
                w_strb <= wstrb_i;
            end else if (do_wr) begin
                w_hold <= 1'b0;
            end
        end
    end

    // register writes and write answer; all fields sit in lane 0
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ctrl <= lduc_pkg::CTRL_RST;
            mask <= lduc_pkg::MASK_RST;
            bvalid_o <= 1'b0;
            bresp_o <= lduc_pkg::RESP_OKAY;
        end else if (do_wr) begin
            bvalid_o <= 1'b1;
            bresp_o <= lduc_pkg::RESP_OKAY;
            if (aw_addr == lduc_pkg::REG_CTRL) begin
                if (w_strb[0]) begin
                    ctrl <= w_data[4:0];
                end
            end else if (aw_addr == lduc_pkg::REG_MASK) begin
                if (w_strb[0]) begin
                    mask <= w_data[4:0];
                end
            end else if (aw_addr != lduc_pkg::REG_STATUS && aw_addr != lduc_pkg::REG_INFO) begin
                bresp_o <= lduc_pkg::RESP_SLVERR; // unmapped
            end
        end else if (bvalid_o && bready_i) begin
            bvalid_o <= 1'b0;
        end
    end

    // read answer; status read also clears what it returned
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rvalid_o <= 1'b0;
            rdata_o <= 32'h0;
            rresp_o <= lduc_pkg::RESP_OKAY;
        end else if (arvalid_i && arready_o) begin
            rvalid_o <= 1'b1;
            rresp_o <= lduc_pkg::RESP_OKAY;
            case (araddr_i)
                lduc_pkg::REG_CTRL: rdata_o <= {27'h0, ctrl};
                lduc_pkg::REG_STATUS: rdata_o <= {27'h0, stat};
                lduc_pkg::REG_MASK: rdata_o <= {27'h0, mask};
                lduc_pkg::REG_INFO: rdata_o <= {27'h0, exc, state};
                default: begin
                    rdata_o <= 32'h0;
                    rresp_o <= lduc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_o && rready_i) begin
            rvalid_o <= 1'b0;
        end
    end

    // exception event decoded to its status bit
    always_comb begin
        ev = 5'h00;
        if (state == lduc_pkg::ST_DONE && exc != lduc_pkg::EXC_NONE) begin
            ev[3'(exc) - 3'h1] = 1'b1;
        end
    end

    // sticky events; a new event beats the read clear
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            stat <= 5'h00;
        end else begin
            stat <= (stat & ~(rd_stat ? stat : 5'h00)) | ev;
        end
    end

    assign irq_o = |(stat & mask);

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    a_ld_align: assert property (acc && d_op == lduc_pkg::OP_LOAD_DOUBLEWORD
        && |d_ea[2:0] && !d_rsv |=> state == lduc_pkg::ST_DONE && exc == lduc_pkg::EXC_ADDR)
        else $error("misaligned doubleword not faulted");
    a_dw_mode: assert property (acc && d_dw && !mode64 && !kernel
        |=> exc == lduc_pkg::EXC_RSV && wb_valid_o)
        else $error("reserved instruction not raised");
    a_merge_noalign: assert property (acc && (d_op == lduc_pkg::OP_LEFT_MERGE
        || d_op == lduc_pkg::OP_RIGHT_MERGE) && !d_rsv |=> state == lduc_pkg::ST_REQ)
        else $error("merge load did not reach memory");
    a_left_offset: assert property (mreq_valid_o && op == lduc_pkg::OP_LEFT_MERGE
        && !mem_byte_order |-> mreq_o.poff == 3'h0)
        else $error("left merge offset not cleared");
    a_right_offset: assert property (acc && d_op == lduc_pkg::OP_RIGHT_MERGE
        && !mem_byte_order |=> poff == ($past(d_ea[2:0]) ^ {3{user_order_flip}}))
        else $error("right merge offset wrong");
    a_half_align: assert property (acc && (d_op == lduc_pkg::OP_SIGNED_HALF
        || d_op == lduc_pkg::OP_UNSIGNED_HALF) && d_ea[0] |=> exc == lduc_pkg::EXC_ADDR)
        else $error("odd halfword not faulted");
    a_word_align: assert property (acc && d_op == lduc_pkg::OP_WORD_LOAD
        && d_ea[1:0] != 2'h0 |=> wb_valid_o && wb_o.exc == lduc_pkg::EXC_ADDR)
        else $error("misaligned word not faulted");
    a_upper_imm: assert property (acc && d_op == lduc_pkg::OP_UPPER_IMM && mode64
        |=> wb_valid_o && wb_o.exc == lduc_pkg::EXC_NONE && wb_o.data[15:0] == 16'h0
        && wb_o.data[31:16] == $past(d_off) && wb_o.data[63:32] == {32{wb_o.data[31]}})
        else $error("upper immediate result wrong");
    a_ld_data: assert property (state == lduc_pkg::ST_RESP && mrsp_valid_i
        && op == lduc_pkg::OP_LOAD_DOUBLEWORD |=> wb_valid_o && wb_o.data == $past(mrsp_i.data))
        else $error("doubleword data not written back");
    a_forward: assert property (acc && fwd_v && d_dest == fwd_reg
        |=> old == $past(fwd_data))
        else $error("pending result not forwarded");
    a_bus_fault: assert property (state == lduc_pkg::ST_RESP && mrsp_valid_i
        && mrsp_i.bus_err && !mrsp_i.refill && !mrsp_i.invalid |=> exc == lduc_pkg::EXC_BUS)
        else $error("bus error not reported");

    c_left: cover property (wb_valid_o && op == lduc_pkg::OP_LEFT_MERGE);
    c_right: cover property (wb_valid_o && op == lduc_pkg::OP_RIGHT_MERGE);
    c_fwd: cover property (acc && fwd_v && d_dest == fwd_reg);
    c_irq: cover property (irq_o);
endmodule

// ### dv/lduc_mem_model.sv
module lduc_mem_model (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // load requests from the block
    input wire logic mreq_valid_i,
    input wire lduc_pkg::lduc_mreq_t mreq_i,
    output logic mreq_ready_o,
    // load answers to the block
    output logic mrsp_valid_o,
    output lduc_pkg::lduc_mrsp_t mrsp_o,
    // bench controls: fault flags, stalling
    input wire logic [2:0] fault_i,
    input wire logic slow_i
);
    // memory bytes, lane 0 in the low bits
    localparam logic [63:0] MEM_WORD = 64'h9192939495969798;
    logic phase; // slow mode takes only every other cycle
    ////////////////////////////////////////////////////////////////
    // stall phase
    always_ff @(posedge mclk_i) begin
        phase <= sys_rst_i ? 1'b0 : !phase;
    end
    assign mreq_ready_o = mreq_valid_i && (!slow_i || phase);
    // answer one cycle after each take
    always_ff @(posedge mclk_i) begin
        mrsp_valid_o <= !sys_rst_i && mreq_valid_i && mreq_ready_o;
    end
    // junk on the data lines outside the answer, so stale values never pass
    assign mrsp_o = {mrsp_valid_o ? MEM_WORD : ~MEM_WORD, fault_i};
endmodule

// ### dv/lduc_tb_top.sv
module lduc_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] OLD = 64'ha1a2a3a4a5a6a7a8; // stale destination value
    logic mclk = 1'b0, rst = 1'b1, iss_valid = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, slow = 1'b0;
    logic iss_ready, wb_valid, mreq_valid, mreq_ready, mrsp_valid;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [2:0] fault = 3'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    lduc_pkg::lduc_iss_t iss = '0;
    lduc_pkg::lduc_wb_t wb;
    lduc_pkg::lduc_mreq_t mreq;
    lduc_pkg::lduc_mrsp_t mrsp;
    int failures = 0, n_tests = 0, guard = 0;
    lduc_core u_lduc_core (.mclk_i(mclk), .sys_rst_i(rst), .iss_valid_i(iss_valid), .iss_i(iss),
        .iss_ready_o(iss_ready), .wb_valid_o(wb_valid), .wb_o(wb), .mreq_valid_o(mreq_valid),
        .mreq_o(mreq), .mreq_ready_i(mreq_ready), .mrsp_valid_i(mrsp_valid), .mrsp_i(mrsp),
        .awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata),
        .wstrb_i(4'hf), .wvalid_i(wvalid), .wready_o(wready), .bresp_o(bresp),
        .bvalid_o(bvalid), .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid),
        .arready_o(arready), .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid),
        .rready_i(rready), .irq_o(irq));
    lduc_mem_model u_lduc_mem_model (.mclk_i(mclk), .sys_rst_i(rst), .mreq_valid_i(mreq_valid),
        .mreq_i(mreq), .mreq_ready_o(mreq_ready), .mrsp_valid_o(mrsp_valid), .mrsp_o(mrsp),
        .fault_i(fault), .slow_i(slow));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // one edge; a hang ends the run as a mismatch
    task automatic tick();
        @(posedge mclk);
        guard++;
        if (guard > 300) begin
            failures++;
            print_verdict();
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        guard = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            tick();
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk("bresp", 64'h0, 64'(bresp));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        guard = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            tick();
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk("rdata", 64'(d), 64'(rdata));
        chk("rresp", 64'(r), 64'(rresp));
    endtask
    // issue one load to register 3, base 0x1000; pf bit 3 means no memory request
    task automatic ld(input logic [5:0] op, input logic [15:0] off, input logic [63:0] exp,
            input logic [2:0] exc, input logic [3:0] pf, input int gap = 1);
        logic [3:0] seen;
        guard = 0;
        seen = 4'h8;
        repeat (gap) tick();
        iss <= '{instr: {op, 5'd1, 5'd3, off}, base: 64'h1000, dest_val: OLD};
        iss_valid <= 1'b1;
        do begin
            tick();
            if (iss_ready) iss_valid <= 1'b0;
            if (mreq_valid && mreq_ready) begin
                seen = {1'b0, mreq.poff};
                chk("virtual_address", 64'h1000 + {{48{off[15]}}, off}, mreq.virtual_address);
                chk("mop", 64'(op), 64'(mreq.op));
            end
        end while (!wb_valid);
        chk("exc", 64'(exc), 64'(wb.exc));
        chk("dest", 64'h3, 64'(wb.dest));
        if (exc == 3'd0) chk("data", exp, wb.data);
        chk("poff", 64'(pf), 64'(seen));
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        forever #4 mclk = !mclk;
    end
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        ld(6'h37, 16'hfff8, 64'h0, 3'd2, 4'h8);
        wr(8'h00, 32'h1);
        ld(6'h37, 16'hfff8, 64'h9192939495969798, 3'd0, 4'h0);
        ld(6'h1a, 16'h0004, 64'h9495969798969798, 3'd0, 4'h0, 0);
        ld(6'h1b, 16'hfff4, 64'h9495969791929394, 3'd0, 4'h4);
        ld(6'h21, 16'h0002, 64'hffffffffffff9596, 3'd0, 4'h2);
        ld(6'h25, 16'h0003, 64'h0, 3'd1, 4'h8);
        ld(6'h23, 16'h0004, 64'hffffffff91929394, 3'd0, 4'h4);
        ld(6'h0f, 16'h8001, 64'hffffffff80010000, 3'd0, 4'h8);
        ld(6'h37, 16'h0004, 64'h0, 3'd1, 4'h8);
        fault <= 3'b100;
        slow <= 1'b1;
        ld(6'h37, 16'h0008, 64'h0, 3'd3, 4'h0);
        chk("irq", 64'h0, 64'(irq));
        wr(8'h08, 32'h1);
        tick();
        chk("irq", 64'h1, 64'(irq));
        rd(8'h04, 32'h7, 2'h0);
        tick();
        chk("irq", 64'h0, 64'(irq));
        rd(8'h10, 32'h0, 2'h2);
        // 32-bit kernel, big-endian memory, flipped order, big-endian processor
        fault <= 3'h0;
        wr(8'h00, 32'h1e);
        ld(6'h1a, 16'h0001, 64'h92939495969798a8, 3'd0, 4'h6);
        ld(6'h1b, 16'h0002, 64'h9293949596919293, 3'd0, 4'h0);
        ld(6'h21, 16'h0002, 64'hffffffffffff9394, 3'd0, 4'h2);
        ld(6'h23, 16'h0000, 64'h0000000091929394, 3'd0, 4'h0);
        ld(6'h0f, 16'h8001, 64'h0000000080010000, 3'd0, 4'h8);
        print_verdict();
    end
endmodule
